// ---- include/pcl_if.sv ----
interface pcl_edge_if;
  logic raw;
  logic rise_sel;
  logic hit;
  modport det (input raw, input rise_sel, output hit);
  modport user (output raw, output rise_sel, input hit);
endinterface

interface pcl_dual_if;
  logic [2:0] mode;
  logic trigger;
  logic edge_hit;
  logic line_out;
  logic line_oe;
  modport drv (input mode, input trigger, input edge_hit, output line_out, output line_oe);
  modport user (output mode, output trigger, output edge_hit, input line_out, input line_oe);
endinterface

// ---- include/pcl_pkg.sv ----
package pcl_pkg;

  // Register select codes
  localparam logic [1:0] REG_PORT_A = 2'h0;
  localparam logic [1:0] REG_CTRL_A = 2'h1;
  localparam logic [1:0] REG_PORT_B = 2'h2;
  localparam logic [1:0] REG_CTRL_B = 2'h3;

  // Control register fields
  localparam int CR_FLAG_EDGE = 7;
  localparam int CR_FLAG_DUAL = 6;
  localparam int CR_DUAL_DIR = 5;
  localparam int CR_DUAL_B4 = 4;
  localparam int CR_DUAL_B3 = 3;
  localparam int CR_DATA_SEL = 2;
  localparam int CR_EDGE_RISE = 1;
  localparam int CR_EDGE_IEN = 0;
  localparam int CR_MODE_LSB = 3;

  localparam logic [7:0] CR_WRITE_MASK = 8'h3F;
  localparam logic [7:0] CR_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] DIR_READ_VALUE = 8'h00;
  localparam logic [7:0] RD_DATA_RESET = 8'h00;
  localparam logic LINE_IDLE_LEVEL = 1'h1;

  // Dual-line modes, from control bits 5,4,3
  localparam logic [2:0] DM_CODE_HANDSHAKE = 3'h4;
  localparam logic [2:0] DM_CODE_PULSE = 3'h5;

  localparam int SIDE_A = 0;
  localparam int SIDE_B = 1;
  localparam int NUM_SIDES = 2;

  typedef enum logic [3:0] {
    PCL_DM_INPUT = 4'h1,
    PCL_DM_HANDSHAKE = 4'h2,
    PCL_DM_PULSE = 4'h4,
    PCL_DM_MANUAL = 4'h8
  } pcl_dual_mode_t;

endpackage

// ---- rtl/pcl_dual_line.sv ----
module pcl_dual_line
  import pcl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Mode, trigger and line drive
  pcl_dual_if.drv dif
);

  typedef struct packed {
    logic line_out;
    logic line_oe;
  } pcl_dual_state_t;

  pcl_dual_state_t st;
  pcl_dual_state_t next_st;
  pcl_dual_mode_t mode;

  always_comb
  begin
    if (!dif.mode[2])
    begin
      mode = PCL_DM_INPUT;
    end
    else if (dif.mode == DM_CODE_HANDSHAKE)
    begin
      mode = PCL_DM_HANDSHAKE;
    end
    else if (dif.mode == DM_CODE_PULSE)
    begin
      mode = PCL_DM_PULSE;
    end
    else
    begin
      mode = PCL_DM_MANUAL;
    end
  end

  always_comb
  begin
    next_st = st;
    next_st.line_oe = dif.mode[2];
    unique case (mode)
      PCL_DM_INPUT:
      begin
        next_st.line_out = LINE_IDLE_LEVEL;
      end
      PCL_DM_HANDSHAKE:
      begin
        // Peripheral edge wins if it meets the processor access
        if (dif.edge_hit)
        begin
          next_st.line_out = 1'h1;
        end
        else if (dif.trigger)
        begin
          next_st.line_out = 1'h0;
        end
      end
      PCL_DM_PULSE:
      begin
        next_st.line_out = !dif.trigger;
      end
      PCL_DM_MANUAL:
      begin
        next_st.line_out = dif.mode[0];
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st.line_out <= LINE_IDLE_LEVEL;
      st.line_oe <= 1'h0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign dif.line_out = st.line_out;
  assign dif.line_oe = st.line_oe;

endmodule

// ---- rtl/pcl_edge_det.sv ----
module pcl_edge_det
  import pcl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Line and edge pulse
  pcl_edge_if.det eif
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } pcl_edge_state_t;

  pcl_edge_state_t st;
  pcl_edge_state_t next_st;

  // Only s2 and s3 feed the detector; s1 is the metastability stage
  always_comb
  begin
    next_st = st;
    next_st.s1 = eif.raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Polarity change cannot fake an edge: both samples must differ
  assign eif.hit = (st.s2 != st.s3) && (st.s2 == eif.rise_sel);

endmodule

// ---- rtl/pcl_top.sv ----
// Contract
// - Side-A edge-input active edge sets flag bit 7
// - Bit 1 picks edge: 0 falling, 1 rising
// - Flag 7 with enable bit 0 pulls irq low
// - Flag 7 sets whatever enable bit 0 holds
// - Bit 5 low: dual line input, flag 6
// - Flag 6 with enable bit 3 pulls irq low
// - Flag 6 sets whatever enable bit 3 holds
// - A handshake: edge raises, data read lowers
// - A pulse: one low cycle after read
// - Bits 5,4 set: line follows bit 3
// - Side-B edge input works as side A
// - Side-B dual input works as side A
// - B handshake: data write lowers, edge raises
// - B pulse: one low cycle after write
// - Side-B outputs triggered by writes, not reads
// - Reading side-A data clears flags 6, 7
// - Reading side-B data clears flags 6, 7
// - Irq low on flag 7&bit 0 or 6&bit 3
module pcl_top
  import pcl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Processor register port
  input wire logic chip_sel,
  input wire logic [1:0] reg_sel,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  // Port data
  input wire logic [7:0] side_a_port_lines,
  output logic [7:0] side_b_output_latch,
  // Side A control lines
  input wire logic side_a_edge_input,
  input wire logic side_a_dual_line_in,
  output logic side_a_dual_line_out,
  output logic side_a_dual_line_oe,
  output logic side_a_irq_n,
  // Side B control lines
  input wire logic side_b_edge_input,
  input wire logic side_b_dual_line_in,
  output logic side_b_dual_line_out,
  output logic side_b_dual_line_oe,
  output logic side_b_irq_n
);

  typedef struct packed {
    logic [NUM_SIDES-1:0][7:0] ctrl;
    logic [7:0] rd_data;
    logic [7:0] b_latch;
  } pcl_top_state_t;

  pcl_top_state_t st;
  pcl_top_state_t next_st;

  logic rd_access;
  logic wr_access;
  logic [NUM_SIDES-1:0] data_read;
  logic [NUM_SIDES-1:0] data_write;
  logic [NUM_SIDES-1:0] edge_hit;
  logic [NUM_SIDES-1:0] dual_hit;
  logic [NUM_SIDES-1:0] edge_raw;
  logic [NUM_SIDES-1:0] dual_raw;
  logic [NUM_SIDES-1:0] line_out;
  logic [NUM_SIDES-1:0] line_oe;
  logic [NUM_SIDES-1:0] irq_n;

  assign rd_access = chip_sel && rd_en;
  assign wr_access = chip_sel && wr_en;

  // Data accesses only count when bit 2 selects the data register
  assign data_read[SIDE_A] = rd_access && (reg_sel == REG_PORT_A)
    && st.ctrl[SIDE_A][CR_DATA_SEL];
  assign data_read[SIDE_B] = rd_access && (reg_sel == REG_PORT_B)
    && st.ctrl[SIDE_B][CR_DATA_SEL];
  assign data_write[SIDE_A] = wr_access && (reg_sel == REG_PORT_A)
    && st.ctrl[SIDE_A][CR_DATA_SEL];
  assign data_write[SIDE_B] = wr_access && (reg_sel == REG_PORT_B)
    && st.ctrl[SIDE_B][CR_DATA_SEL];

  assign edge_raw[SIDE_A] = side_a_edge_input;
  assign edge_raw[SIDE_B] = side_b_edge_input;
  assign dual_raw[SIDE_A] = side_a_dual_line_in;
  assign dual_raw[SIDE_B] = side_b_dual_line_in;

  generate
    for (genvar s = 0; s < NUM_SIDES; s++)
    begin : g_side
      pcl_edge_if edge_bus();
      pcl_edge_if dual_bus();
      pcl_dual_if line_bus();

      assign edge_bus.raw = edge_raw[s];
      assign edge_bus.rise_sel = st.ctrl[s][CR_EDGE_RISE];
      assign edge_hit[s] = edge_bus.hit;

      assign dual_bus.raw = dual_raw[s];
      assign dual_bus.rise_sel = st.ctrl[s][CR_DUAL_B4];
      assign dual_hit[s] = dual_bus.hit;

      assign line_bus.mode = st.ctrl[s][CR_DUAL_DIR:CR_MODE_LSB];
      // Side A pulses on reads, side B on writes
      assign line_bus.trigger = (s == SIDE_A) ? data_read[s] : data_write[s];
      assign line_bus.edge_hit = edge_hit[s];
      assign line_out[s] = line_bus.line_out;
      assign line_oe[s] = line_bus.line_oe;

      pcl_edge_det u_edge (
        .clk(clk),
        .sys_rst(sys_rst),
        .eif(edge_bus.det)
      );

      pcl_edge_det u_dual_in (
        .clk(clk),
        .sys_rst(sys_rst),
        .eif(dual_bus.det)
      );

      pcl_dual_line u_line (
        .clk(clk),
        .sys_rst(sys_rst),
        .dif(line_bus.drv)
      );

      assign irq_n[s] = !((st.ctrl[s][CR_FLAG_EDGE] && st.ctrl[s][CR_EDGE_IEN])
        || (st.ctrl[s][CR_FLAG_DUAL] && st.ctrl[s][CR_DUAL_B3]));
    end
  endgenerate

  always_comb
  begin
    next_st = st;

    // Read data mirrors the state before any clear of this same access
    if (rd_access)
    begin
      unique case (reg_sel)
        REG_PORT_A:
        begin
          next_st.rd_data = st.ctrl[SIDE_A][CR_DATA_SEL] ? side_a_port_lines : DIR_READ_VALUE;
        end
        REG_CTRL_A:
        begin
          next_st.rd_data = st.ctrl[SIDE_A];
        end
        REG_PORT_B:
        begin
          next_st.rd_data = st.ctrl[SIDE_B][CR_DATA_SEL] ? st.b_latch : DIR_READ_VALUE;
        end
        REG_CTRL_B:
        begin
          next_st.rd_data = st.ctrl[SIDE_B];
        end
      endcase
    end

    if (data_write[SIDE_B])
    begin
      next_st.b_latch = wr_data;
    end

    if (wr_access && (reg_sel == REG_CTRL_A))
    begin
      next_st.ctrl[SIDE_A] = (st.ctrl[SIDE_A] & ~CR_WRITE_MASK)
        | (wr_data & CR_WRITE_MASK);
    end
    if (wr_access && (reg_sel == REG_CTRL_B))
    begin
      next_st.ctrl[SIDE_B] = (st.ctrl[SIDE_B] & ~CR_WRITE_MASK)
        | (wr_data & CR_WRITE_MASK);
    end

    for (int s = 0; s < NUM_SIDES; s++)
    begin
      // Clear first, so an edge in the same cycle still sets the flag
      if (data_read[s])
      begin
        next_st.ctrl[s][CR_FLAG_EDGE] = 1'h0;
        next_st.ctrl[s][CR_FLAG_DUAL] = 1'h0;
      end
      if (edge_hit[s])
      begin
        next_st.ctrl[s][CR_FLAG_EDGE] = 1'h1;
      end
      // Flag 6 only listens while the dual line is an input
      if (dual_hit[s] && !st.ctrl[s][CR_DUAL_DIR])
      begin
        next_st.ctrl[s][CR_FLAG_DUAL] = 1'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st.ctrl <= {CR_RESET, CR_RESET};
      st.rd_data <= RD_DATA_RESET;
      st.b_latch <= LATCH_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign side_b_output_latch = st.b_latch;
  // Handshake low tells the peripheral it may present the next byte
  assign side_a_dual_line_out = line_out[SIDE_A];
  assign side_a_dual_line_oe = line_oe[SIDE_A];
  assign side_b_dual_line_out = line_out[SIDE_B];
  assign side_b_dual_line_oe = line_oe[SIDE_B];
  assign side_a_irq_n = irq_n[SIDE_A];
  assign side_b_irq_n = irq_n[SIDE_B];

endmodule

// ---- sim/pcl_periph.sv ----
module pcl_periph
(
  // Clock and enable
  input wire logic clk,
  input wire logic go,
  // Handshake lines
  input wire logic dual_out,
  output logic edge_out,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    edge_out = 1'h0;
    data = 8'h00;
    forever
    begin
      @(posedge clk);
      if (go)
      begin
        repeat ($urandom_range(3)) @(posedge clk);
        #1;
        data = 8'($urandom);
        edge_out = 1'h1;
        while (!dual_out) @(posedge clk);
        while (dual_out) @(posedge clk);
        #1;
        edge_out = 1'h0;
        // Data is no longer held once taken
        data = ~data;
      end
    end
  end
endmodule

// ---- sim/pcl_props.sv ----
module pcl_props
  import pcl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic chip_sel,
  input wire logic [1:0] reg_sel,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // Control lines
  input wire logic side_a_edge_input,
  input wire logic side_a_dual_line_in,
  input wire logic side_a_dual_line_out,
  input wire logic side_a_dual_line_oe,
  input wire logic side_a_irq_n,
  input wire logic side_b_edge_input,
  input wire logic side_b_dual_line_out,
  input wire logic side_b_irq_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] side_a_control;
  logic [5:0] side_b_control;
  wire logic rd_a = chip_sel && rd_en && reg_sel == REG_PORT_A && side_a_control[CR_DATA_SEL];
  wire logic wr_b = chip_sel && wr_en && reg_sel == REG_PORT_B && side_b_control[CR_DATA_SEL];
  // Shadow of the writable bits, since the checker cannot see the mode
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      side_a_control <= 6'h00;
      side_b_control <= 6'h00;
    end
    else if (chip_sel && wr_en && reg_sel == REG_CTRL_A)
      side_a_control <= wr_data[5:0];
    else if (chip_sel && wr_en && reg_sel == REG_CTRL_B)
      side_b_control <= wr_data[5:0];
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Mode must still be pulse when the line is restored one edge later
  sequence s_rd_pulse_a;
    (side_a_control[5:3] == DM_CODE_PULSE && rd_a) ##1 (side_a_control[5:3] == DM_CODE_PULSE && !rd_a);
  endsequence
  sequence s_wr_pulse_b;
    (side_b_control[5:3] == DM_CODE_PULSE && wr_b) ##1 (side_b_control[5:3] == DM_CODE_PULSE && !wr_b);
  endsequence
  // Edge reaches the flag two edges after it is sampled, so irq is seen at the third
  sequence s_rise_a;
    (side_a_control[1:0] == 2'h3 && $rose(side_a_edge_input)) ##1 (side_a_control[1:0] == 2'h3 && !rd_a) [*3];
  endsequence
  sequence s_quiet_a;
    $stable({side_a_edge_input, side_a_dual_line_in}) [*3];
  endsequence
  property p_irq_off_a;
    !side_a_control[CR_EDGE_IEN] && !side_a_control[CR_DUAL_B3] |-> side_a_irq_n;
  endproperty
  property p_oe_a;
    side_a_dual_line_oe == $past(side_a_control[CR_DUAL_DIR]);
  endproperty
  property p_manual_a;
    (side_a_control[5:4] == 2'h3) [*2] |-> side_a_dual_line_out == $past(side_a_control[CR_DUAL_B3]);
  endproperty
  property p_pulse_a;
    s_rd_pulse_a |-> !side_a_dual_line_out ##1 side_a_dual_line_out;
  endproperty
  // An edge hit at the access edge would win, so the input must be quiet before
  property p_hshk_a;
    $stable(side_a_edge_input) ##2 (side_a_control[5:3] == DM_CODE_HANDSHAKE && rd_a)
      |=> !side_a_dual_line_out;
  endproperty
  property p_clear_a;
    s_quiet_a ##0 rd_a |=> side_a_irq_n;
  endproperty
  property p_set_a;
    s_rise_a |-> !side_a_irq_n;
  endproperty
  property p_pulse_b;
    s_wr_pulse_b |-> !side_b_dual_line_out ##1 side_b_dual_line_out;
  endproperty
  property p_hshk_b;
    $stable(side_b_edge_input) ##2 (side_b_control[5:3] == DM_CODE_HANDSHAKE && wr_b)
      |=> !side_b_dual_line_out;
  endproperty
  property p_irq_off_b;
    !side_b_control[CR_EDGE_IEN] && !side_b_control[CR_DUAL_B3] |-> side_b_irq_n;
  endproperty
  a_irq_off_a: assert property (p_irq_off_a)
    else $error("irq a low while disabled");
  a_oe_a: assert property (p_oe_a)
    else $error("dual a enable wrong");
  a_manual_a: assert property (p_manual_a)
    else $error("dual a manual level wrong");
  a_pulse_a: assert property (p_pulse_a)
    else $error("dual a pulse wrong");
  a_hshk_a: assert property (p_hshk_a)
    else $error("dual a not low after read");
  a_clear_a: assert property (p_clear_a)
    else $error("flags a not cleared by read");
  a_set_a: assert property (p_set_a)
    else $error("flag a edge not seen in time");
  a_pulse_b: assert property (p_pulse_b)
    else $error("dual b pulse wrong");
  a_hshk_b: assert property (p_hshk_b)
    else $error("dual b not low after write");
  a_irq_off_b: assert property (p_irq_off_b)
    else $error("irq b low while disabled");
endmodule
bind pcl_top pcl_props u_props (
  .clk(clk),
  .sys_rst(sys_rst),
  .chip_sel(chip_sel),
  .reg_sel(reg_sel),
  .rd_en(rd_en),
  .wr_en(wr_en),
  .wr_data(wr_data),
  .side_a_edge_input(side_a_edge_input),
  .side_a_dual_line_in(side_a_dual_line_in),
  .side_a_dual_line_out(side_a_dual_line_out),
  .side_a_dual_line_oe(side_a_dual_line_oe),
  .side_a_irq_n(side_a_irq_n),
  .side_b_edge_input(side_b_edge_input),
  .side_b_dual_line_out(side_b_dual_line_out),
  .side_b_irq_n(side_b_irq_n)
);

// ---- sim/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pcl_pkg::*;
  logic clk = 1'h0, sys_rst = 1'h1, chip_sel = 1'h0, rd_en = 1'h0, wr_en = 1'h0;
  logic [1:0] reg_sel = 2'h0, cr;
  logic [7:0] wr_data = 8'h00, rd_data, b_latch, p_data, cfg, d;
  logic ea = 1'h0, eb = 1'h0, da = 1'h0, db = 1'h0, use_p = 1'h0, p_edge, s, pol, en;
  logic a_out, a_oe, a_irq, b_out, b_oe, b_irq;
  int fails = 0, checks = 0;
  wire logic a_edge = use_p ? p_edge : ea;
  wire logic a_dl = a_oe ? a_out : da;
  wire logic b_dl = b_oe ? b_out : db;
  always #20 clk = ~clk;
  pcl_top dut
  (
    .clk(clk), .sys_rst(sys_rst), .chip_sel(chip_sel), .reg_sel(reg_sel),
    .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data),
    .side_a_port_lines(p_data), .side_b_output_latch(b_latch),
    .side_a_edge_input(a_edge), .side_a_dual_line_in(a_dl),
    .side_a_dual_line_out(a_out), .side_a_dual_line_oe(a_oe), .side_a_irq_n(a_irq),
    .side_b_edge_input(eb), .side_b_dual_line_in(b_dl),
    .side_b_dual_line_out(b_out), .side_b_dual_line_oe(b_oe), .side_b_irq_n(b_irq)
  );
  pcl_periph peri
  (
    .clk(clk), .go(use_p), .dual_out(a_dl), .edge_out(p_edge), .data(p_data)
  );
  function automatic logic [7:0] in_cfg(input logic p, input logic e);
    return {3'h0, p, e, 1'h1, p, e};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Lets an edge pass first, so back-to-back calls never retoggle a strobe in one step
  task automatic acc(input logic [1:0] r, input logic w, input logic [7:0] v);
    @(posedge clk);
    #1;
    chip_sel = 1'h1;
    reg_sel = r;
    rd_en = !w;
    wr_en = w;
    wr_data = v;
    @(posedge clk);
    #1;
    chip_sel = 1'h0;
    rd_en = 1'h0;
    wr_en = 1'h0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic drv(input logic side, input logic v);
    if (side)
      {eb, db} = {v, v};
    else
      {ea, da} = {v, v};
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #(40 * 4000);
    fails++;
    conclude();
  end
  initial
  begin
    void'($urandom(32'h55E4DDFD));
    tick(5);
    sys_rst = 1'h0;
    acc(REG_CTRL_A, 1'h0, 8'h00);
    chk(rd_data, CR_RESET);
    acc(REG_CTRL_B, 1'h0, 8'h00);
    chk(rd_data, CR_RESET);
    chk(8'({a_irq, b_irq, a_out, b_out, a_oe, b_oe}), 8'h3C);
    // Data select still low: these reach the direction side only
    acc(REG_PORT_A, 1'h0, 8'h00);
    chk(rd_data, DIR_READ_VALUE);
    acc(REG_PORT_B, 1'h1, 8'($urandom));
    chk(b_latch, LATCH_RESET);
    $display("test reset done");
    // Opposite level first (a wrong edge except rising with enable off), then the right one, flags written as ones on purpose
    for (int k = 0; k < 8; k++)
    begin
      {s, pol, en} = 3'(k);
      cr = s ? REG_CTRL_B : REG_CTRL_A;
      cfg = in_cfg(pol, en);
      acc(cr, 1'h1, 8'hC0 | cfg);
      acc(s ? REG_PORT_B : REG_PORT_A, 1'h0, 8'h00);
      drv(s, !pol);
      tick(4);
      acc(cr, 1'h0, 8'h00);
      chk(rd_data, cfg);
      drv(s, pol);
      tick(4);
      chk(8'(s ? b_irq : a_irq), 8'(!en));
      acc(cr, 1'h0, 8'h00);
      chk(rd_data, 8'hC0 | cfg);
    end
    $display("test edge inputs done");
    acc(REG_CTRL_A, 1'h1, 8'h2C);
    acc(REG_CTRL_B, 1'h1, 8'h2C);
    for (int j = 0; j < 6; j++)
    begin
      s = 1'(j);
      d = 8'($urandom);
      acc(s ? REG_PORT_B : REG_PORT_A, s, d);
      // Low stands from the access edge to the next one
      chk(8'(s ? b_out : a_out), 8'h00);
      tick(1);
      chk(8'(s ? b_out : a_out), 8'h01);
      if (s)
        chk(b_latch, d);
    end
    acc(REG_PORT_B, 1'h0, 8'h00);
    chk(rd_data, d);
    chk(8'(b_out), 8'h01);
    $display("test pulse done");
    for (int v = 0; v < 2; v++)
    begin
      acc(REG_CTRL_A, 1'h1, 8'h34 | 8'(v << 3));
      acc(REG_CTRL_B, 1'h1, 8'h34 | 8'(v << 3));
      tick(1);
      chk(8'({a_out, b_out, a_oe, b_oe}), {4'h0, 1'(v), 1'(v), 2'h3});
    end
    $display("test manual done");
    acc(REG_CTRL_A, 1'h1, 8'h27);
    use_p = 1'h1;
    for (int j = 0; j < 5; j++)
    begin
      repeat (50) if (a_irq !== 1'h0) tick(1);
      chk(8'(a_out), 8'h01);
      d = p_data;
      acc(REG_PORT_A, 1'h0, 8'h00);
      chk(rd_data, d);
      tick(1);
      chk(8'(a_out), 8'h00);
    end
    acc(REG_CTRL_B, 1'h1, 8'h26);
    acc(REG_PORT_B, 1'h1, 8'($urandom));
    tick(1);
    chk(8'(b_out), 8'h00);
    eb = 1'h0;
    tick(3);
    eb = 1'h1;
    tick(4);
    chk(8'(b_out), 8'h01);
    $display("test handshake done");
    conclude();
  end
endmodule
